// file: hw/irq_prio_ctrl.sv
// interrupt priority and nmi edge configuration with axi4-lite registers
// assumes request inputs from logic on aclk, except pins which are synchronised here
//
// Functional notes
// RL1 - system control reloads 09 on reset, standby
// RL2 - software standby leaves system control untouched
// RL3 - select 0: user flag masks; 1: plain bit
// RL4 - edge select 0 falling, 1 rising nmi edge
// RL5 - priority register clears on reset, standby; rw
// RL6 - bit 0 low level, bit 1 high level
// RL7 - bit 7 sets external line 0 level
// RL8 - bit 6 sets external line 1 level
// RL9 - bit 5 sets external lines 2,3 level
// RL10 - bit 4 sets external lines 4,5 level
// RL11 - bit 3 sets watchdog, refresh, adc level
// RL12 - bit 2 sets timer16 channel 0 level
// RL13 - bit 1 sets timer16 channel 1 level
// RL14 - nmi highest, always accepted; arbitrate maskable ones
// RL15 - bit 0 sets timer16 channel 2 level
// RL16 - same level: lowest source index wins
module irq_prio_ctrl (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        hw_standby,
  input  wire logic        nmi_pin,
  input  wire logic [5:0]  external_request_lines,
  input  wire logic        watchdog_req,
  input  wire logic        refresh_req,
  input  wire logic        adc_req,
  input  wire logic [2:0]  timer16_req,
  input  wire logic        cpu_i_flag,
  input  wire logic        user_or_mask_flag,
  input  wire logic        nmi_ack,
  output logic             nmi_request,
  output logic             req_valid,
  output logic [3:0]       req_source,
  output logic             req_level,
  output logic             ui_mask_active,
  output logic             irq
);

  // ***************************
  // register decode
  // ***************************
  // offset to register select, 3'd4 means unmapped
  function automatic logic [2:0] reg_sel(input logic [7:0] addr);
    case (addr & 8'hFC)
      irq_prio_pkg::SYSCTL_OFFS: reg_sel = 3'h0;
      irq_prio_pkg::PRIOA_OFFS:  reg_sel = 3'h1;
      irq_prio_pkg::STATUS_OFFS: reg_sel = 3'h2;
      irq_prio_pkg::MASK_OFFS:   reg_sel = 3'h3;
      default:                   reg_sel = 3'h4;
    endcase
  endfunction

  irq_prio_pkg::wr_state_t wr_state_reg, wr_state_next;
  irq_prio_pkg::rd_state_t rd_state_reg, rd_state_next;
  logic [7:0]  sysctl_reg, sysctl_next, prioa_reg, prioa_next;
  logic [7:0]  status_reg, status_next, mask_reg, mask_next;
  logic [7:0]  awaddr_reg, awaddr_next;
  logic [7:0]  wdata_reg, wdata_next;
  logic        wstrb0_reg, wstrb0_next, aw_have_reg, aw_have_next, w_have_reg, w_have_next;
  logic        awready_reg, awready_next, wready_reg, wready_next, bvalid_reg, bvalid_next;
  logic        arready_reg, arready_next, rvalid_reg, rvalid_next;
  logic [1:0]  bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [7:0]  rdata_reg, rdata_next;
  logic        irq_reg, irq_next;
  logic [5:0]  ext_s1, ext_s2;
  logic        stby_s1, stby_s2, stby_s3, nmi_s1, nmi_s2, nmi_s3;
  logic        nmi_edge, stby_entry;

  // ***************************
  // pin synchronisers
  // ***************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_s1  <= 6'h00;
      ext_s2  <= 6'h00;
      stby_s1 <= 1'b0;
      stby_s2 <= 1'b0;
      stby_s3 <= 1'b0;
    end else begin
      ext_s1  <= external_request_lines;
      ext_s2  <= ext_s1;
      stby_s1 <= hw_standby;
      stby_s2 <= stby_s1;
      stby_s3 <= stby_s2;
    end
  end

  // nmi chain runs through reset so it holds the pin level; no false edge after release
  always_ff @(posedge aclk) begin
    nmi_s1 <= nmi_pin;
    nmi_s2 <= nmi_s1;
    nmi_s3 <= nmi_s2;
  end

  // RL4 edge select decode
  assign nmi_edge   = sysctl_reg[irq_prio_pkg::EDGE_BIT] ? (nmi_s2 & ~nmi_s3) : (~nmi_s2 & nmi_s3);
  assign stby_entry = stby_s2 & ~stby_s3;

  // ***************************
  // bus slave and registers
  // ***************************
  // next state of bus channels and register file
  always_comb begin
    logic [7:0] wa;
    logic [7:0] wd;
    logic       ws;
    wa = awaddr_reg;
    wd = wdata_reg;
    ws = wstrb0_reg;
    wr_state_next = wr_state_reg;
    rd_state_next = rd_state_reg;
    sysctl_next   = sysctl_reg;
    prioa_next    = prioa_reg;
    status_next   = status_reg;
    mask_next     = mask_reg;
    awaddr_next   = awaddr_reg;
    wdata_next    = wdata_reg;
    wstrb0_next   = wstrb0_reg;
    aw_have_next  = aw_have_reg;
    w_have_next   = w_have_reg;
    awready_next  = awready_reg;
    wready_next   = wready_reg;
    bvalid_next   = bvalid_reg;
    bresp_next    = bresp_reg;
    arready_next  = arready_reg;
    rvalid_next   = rvalid_reg;
    rresp_next    = rresp_reg;
    rdata_next    = rdata_reg;
    case (wr_state_reg)
      irq_prio_pkg::WR_IDLE: begin
        if (awvalid && awready_reg) begin
          wa           = awaddr;
          awaddr_next  = awaddr;
          aw_have_next = 1'b1;
          awready_next = 1'b0;
        end
        if (wvalid && wready_reg) begin
          wd          = wdata[7:0];
          ws          = wstrb[0];
          wdata_next  = wdata[7:0];
          wstrb0_next = wstrb[0];
          w_have_next = 1'b1;
          wready_next = 1'b0;
        end
        if (aw_have_next && w_have_next) begin
          // RL2 only a bus write, a reset or hardware standby changes system control
          // RL5 every priority bit writable
          case (reg_sel(wa))
            3'h0:    if (ws) sysctl_next = wd;
            3'h1:    if (ws) prioa_next = wd;
            3'h3:    if (ws) mask_next = wd;
            default: ;
          endcase
          bresp_next    = (reg_sel(wa) == 3'h4) ? irq_prio_pkg::RESP_SLVERR : irq_prio_pkg::RESP_OKAY;
          bvalid_next   = 1'b1;
          aw_have_next  = 1'b0;
          w_have_next   = 1'b0;
          wr_state_next = irq_prio_pkg::WR_RESP;
        end
      end
      irq_prio_pkg::WR_RESP: begin
        if (bready) begin
          bvalid_next   = 1'b0;
          awready_next  = 1'b1;
          wready_next   = 1'b1;
          wr_state_next = irq_prio_pkg::WR_IDLE;
        end
      end
      default: wr_state_next = irq_prio_pkg::WR_IDLE;
    endcase
    case (rd_state_reg)
      irq_prio_pkg::RD_IDLE: begin
        if (arvalid) begin
          case (reg_sel(araddr))
            3'h0:    rdata_next = sysctl_reg;
            3'h1:    rdata_next = prioa_reg;
            3'h2:    rdata_next = status_reg;
            3'h3:    rdata_next = mask_reg;
            default: rdata_next = 8'h00;
          endcase
          // status read clears, new events below still set
          if (reg_sel(araddr) == 3'h2) status_next = 8'h00;
          rresp_next    = (reg_sel(araddr) == 3'h4) ? irq_prio_pkg::RESP_SLVERR : irq_prio_pkg::RESP_OKAY;
          rvalid_next   = 1'b1;
          arready_next  = 1'b0;
          rd_state_next = irq_prio_pkg::RD_RESP;
        end
      end
      irq_prio_pkg::RD_RESP: begin
        if (rready) begin
          rvalid_next   = 1'b0;
          arready_next  = 1'b1;
          rd_state_next = irq_prio_pkg::RD_IDLE;
        end
      end
      default: rd_state_next = irq_prio_pkg::RD_IDLE;
    endcase
    // sticky events, set wins over clear
    status_next[irq_prio_pkg::ST_NMI_BIT]  = status_next[irq_prio_pkg::ST_NMI_BIT] | nmi_edge;
    status_next[irq_prio_pkg::ST_STBY_BIT] = status_next[irq_prio_pkg::ST_STBY_BIT] | stby_entry;
    // RL1 standby reloads system control
    // RL5 standby clears priority register
    if (stby_s2) begin
      sysctl_next = irq_prio_pkg::SYSCTL_RESET;
      prioa_next  = irq_prio_pkg::PRIOA_RESET;
    end
    irq_next = |(status_next & mask_reg);
  end

  // register the bus and register file
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_reg <= irq_prio_pkg::WR_IDLE;
      rd_state_reg <= irq_prio_pkg::RD_IDLE;
      sysctl_reg   <= irq_prio_pkg::SYSCTL_RESET;
      prioa_reg    <= irq_prio_pkg::PRIOA_RESET;
      status_reg   <= irq_prio_pkg::STATUS_RESET;
      mask_reg     <= irq_prio_pkg::MASK_RESET;
      awaddr_reg   <= 8'h00;
      wdata_reg    <= 8'h00;
      wstrb0_reg   <= 1'b0;
      aw_have_reg  <= 1'b0;
      w_have_reg   <= 1'b0;
      awready_reg  <= 1'b1;
      wready_reg   <= 1'b1;
      bvalid_reg   <= 1'b0;
      bresp_reg    <= irq_prio_pkg::RESP_OKAY;
      arready_reg  <= 1'b1;
      rvalid_reg   <= 1'b0;
      rresp_reg    <= irq_prio_pkg::RESP_OKAY;
      rdata_reg    <= 8'h00;
      irq_reg      <= 1'b0;
    end else begin
      wr_state_reg <= wr_state_next;
      rd_state_reg <= rd_state_next;
      sysctl_reg   <= sysctl_next;
      prioa_reg    <= prioa_next;
      status_reg   <= status_next;
      mask_reg     <= mask_next;
      awaddr_reg   <= awaddr_next;
      wdata_reg    <= wdata_next;
      wstrb0_reg   <= wstrb0_next;
      aw_have_reg  <= aw_have_next;
      w_have_reg   <= w_have_next;
      awready_reg  <= awready_next;
      wready_reg   <= wready_next;
      bvalid_reg   <= bvalid_next;
      bresp_reg    <= bresp_next;
      arready_reg  <= arready_next;
      rvalid_reg   <= rvalid_next;
      rresp_reg    <= rresp_next;
      rdata_reg    <= rdata_next;
      irq_reg      <= irq_next;
    end
  end

  // ***************************
  // priority arbitration
  // ***************************
  logic [irq_prio_pkg::NUM_SRC-1:0] pend, src_lvl;
  logic        lvl0_ok, lvl1_ok, sel_valid, sel_level, nmi_pend_reg, nmi_pend_next;
  logic [3:0]  sel_idx, req_source_reg, req_source_next;
  logic        req_valid_reg, req_valid_next, req_level_reg, req_level_next, ui_mask_reg, ui_mask_next;

  assign pend = {timer16_req, adc_req, refresh_req, watchdog_req, ext_s2};

  // RL6 level of each source from its priority bit
  // RL7 RL8 RL9 RL10 RL11 RL12 RL13 RL15 source to bit table
  for (genvar g = 0; g < irq_prio_pkg::NUM_SRC; g++) begin : g_lvl
    assign src_lvl[g] = prioa_reg[irq_prio_pkg::PRIO_BIT[g]];
  end

  // RL3 user flag as second mask only when select is 0
  assign lvl0_ok = ~cpu_i_flag;
  assign lvl1_ok = ~cpu_i_flag | (~sysctl_reg[irq_prio_pkg::UFS_BIT] & ~user_or_mask_flag);

  // RL16 scan downward so the lowest index is kept
  // RL14 high level beats low level among maskable requests
  always_comb begin
    sel_valid = 1'b0;
    sel_level = 1'b0;
    sel_idx   = 4'h0;
    for (int i = irq_prio_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (pend[i] && !src_lvl[i] && lvl0_ok && !(sel_valid && sel_level)) begin
        sel_valid = 1'b1;
        sel_idx   = 4'(i);
      end
    end
    for (int i = irq_prio_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (pend[i] && src_lvl[i] && lvl1_ok) begin
        sel_valid = 1'b1;
        sel_level = 1'b1;
        sel_idx   = 4'(i);
      end
    end
    // RL14 nmi pends unconditionally, set wins over ack
    nmi_pend_next   = (nmi_pend_reg & ~nmi_ack) | nmi_edge;
    req_valid_next  = sel_valid;
    req_source_next = sel_idx;
    req_level_next  = sel_level;
    ui_mask_next    = ~sysctl_reg[irq_prio_pkg::UFS_BIT];
  end

  // register the arbitration result
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nmi_pend_reg   <= 1'b0;
      req_valid_reg  <= 1'b0;
      req_source_reg <= 4'h0;
      req_level_reg  <= 1'b0;
      ui_mask_reg    <= 1'b0;
    end else begin
      nmi_pend_reg   <= nmi_pend_next;
      req_valid_reg  <= req_valid_next;
      req_source_reg <= req_source_next;
      req_level_reg  <= req_level_next;
      ui_mask_reg    <= ui_mask_next;
    end
  end

  assign awready = awready_reg;
  assign wready = wready_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = arready_reg;
  assign rvalid = rvalid_reg;
  assign rresp = rresp_reg;
  assign rdata = {24'h000000, rdata_reg};
  assign irq = irq_reg;
  assign nmi_request = nmi_pend_reg;
  assign req_valid = req_valid_reg;
  assign req_source = req_source_reg;
  assign req_level = req_level_reg;
  assign ui_mask_active = ui_mask_reg;

  // ***************************
  // checks
  // ***************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_standby_reload: assert property (stby_s2 |=> sysctl_reg == 8'h09) else $error("sysctl not reloaded"); // RL1
  a_standby_prio: assert property (stby_s2 |=> prioa_reg == 8'h00) else $error("prio not cleared"); // RL5
  a_nmi_falling: assert property (!sysctl_reg[2] && nmi_s3 && !nmi_s2 |=> nmi_pend_reg) else $error("fall missed"); // RL4
  a_nmi_rising: assert property (sysctl_reg[2] && !nmi_s3 && nmi_s2 |=> nmi_pend_reg) else $error("rise missed"); // RL4
  a_ui_mask_sel: assert property (##1 ui_mask_active == !$past(sysctl_reg[3])) else $error("ui mode wrong"); // RL3
  a_ext0_high: assert property (pend[0] && prioa_reg[7] && lvl1_ok |=> req_level && req_source == 4'h0)
    else $error("ext0 lost"); // RL7
  a_ext3_level: assert property (req_valid && req_source == 4'h3 |-> req_level == $past(prioa_reg[5]))
    else $error("ext3 level"); // RL9
  a_adc_level: assert property (req_valid && req_source == 4'h8 |-> req_level == $past(prioa_reg[3]))
    else $error("adc level"); // RL11
  a_tmr2_level: assert property (req_valid && req_source == 4'hB |-> req_level == $past(prioa_reg[0]))
    else $error("timer2 level"); // RL15
  a_user_masks: assert property (cpu_i_flag && !sysctl_reg[3] && user_or_mask_flag |=> !req_valid)
    else $error("mask ignored"); // RL3
  c_nmi_seen: cover property (nmi_edge ##1 nmi_request);
  c_high_pick: cover property (req_valid && req_level);
  c_irq_out: cover property ($rose(irq));

endmodule

// file: hw/irq_prio_pkg.sv
// shared constants and types for the interrupt priority controller
// assumes an axi4-lite master with 32-bit data and byte addresses
package irq_prio_pkg;

  // ***************************
  // register map (byte offsets)
  // ***************************
  localparam logic [7:0] SYSCTL_OFFS = 8'h00;
  localparam logic [7:0] PRIOA_OFFS  = 8'h04;
  localparam logic [7:0] STATUS_OFFS = 8'h08;
  localparam logic [7:0] MASK_OFFS   = 8'h0C;

  // ***************************
  // reset values and fields
  // ***************************
  localparam logic [7:0] SYSCTL_RESET = 8'h09;
  localparam logic [7:0] PRIOA_RESET  = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET   = 8'h00;
  localparam int         UFS_BIT      = 3;  // user_flag_select
  localparam int         EDGE_BIT     = 2;  // nonmask_edge_select
  localparam int         ST_NMI_BIT   = 0;  // nmi edge seen
  localparam int         ST_STBY_BIT  = 1;  // hardware standby entered

  // ***************************
  // sources: 0..5 ext lines, 6 watchdog, 7 refresh, 8 adc, 9..11 timer16 ch0..2
  // ***************************
  localparam int NUM_SRC = 12;
  localparam int PRIO_BIT [NUM_SRC] = '{7, 6, 5, 5, 4, 4, 3, 3, 3, 2, 1, 0};

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {WR_IDLE = 2'b01, WR_RESP = 2'b10} wr_state_t;
  typedef enum logic [1:0] {RD_IDLE = 2'b01, RD_RESP = 2'b10} rd_state_t;

endpackage

// file: tb/cpu_accept_model.sv
// cpu-side model: drives the mask flags and acknowledges nmi requests
// assumes the bench sets wanted flag levels and the ack wait
module cpu_accept_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       nmi_request,
  input  wire logic       want_i,
  input  wire logic       want_ui,
  input  wire logic [3:0] ack_dly,
  output logic            cpu_i_flag,
  output logic            user_or_mask_flag,
  output logic            nmi_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_cnt;
  // flags follow the wanted levels; one-cycle ack after a set wait
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cpu_i_flag        <= 1'b0;
      user_or_mask_flag <= 1'b0;
      nmi_ack           <= 1'b0;
      wait_cnt          <= 4'h0;
    end else begin
      cpu_i_flag        <= want_i;
      user_or_mask_flag <= want_ui;
      nmi_ack           <= 1'b0;
      if (nmi_request && !nmi_ack) begin
        if (wait_cnt == ack_dly) begin
          nmi_ack  <= 1'b1;
          wait_cnt <= 4'h0;
        end else begin
          wait_cnt <= wait_cnt + 4'h1;
        end
      end else begin
        wait_cnt <= 4'h0;
      end
    end
  end
endmodule

// file: tb/irq_priority_nmi_edge_config_tb.sv
// bench for the interrupt priority controller over axi4-lite
// assumes the cpu model in cpu_accept_model.sv
module irq_priority_nmi_edge_config_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, hw_standby, nmi_pin;
  logic        awready, wready, bvalid, arready, rvalid, nmi_request, req_valid, req_level;
  logic        ui_mask_active, irq, nmi_ack, cpu_i_flag, ui_flag, want_i, want_ui;
  logic [7:0]  awaddr, araddr, rd;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb, req_source, ack_dly;
  logic [3:0]  wr_strb = 4'hF;
  logic [1:0]  bresp, rresp;
  logic [11:0] src_vec;
  int          compares, n_mismatch, cyc;
  int          pbit [12] = '{7, 6, 5, 5, 4, 4, 3, 3, 3, 2, 1, 0};
  localparam logic [1:0] OK = irq_prio_pkg::RESP_OKAY;
  localparam logic [7:0] SC = irq_prio_pkg::SYSCTL_OFFS;
  localparam logic [7:0] PA = irq_prio_pkg::PRIOA_OFFS;
  localparam logic [7:0] ST = irq_prio_pkg::STATUS_OFFS;
  localparam logic [7:0] MK = irq_prio_pkg::MASK_OFFS;

  irq_prio_ctrl dut_u (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .hw_standby(hw_standby), .nmi_pin(nmi_pin),
    .external_request_lines(src_vec[5:0]), .watchdog_req(src_vec[6]), .refresh_req(src_vec[7]),
    .adc_req(src_vec[8]), .timer16_req(src_vec[11:9]), .cpu_i_flag(cpu_i_flag),
    .user_or_mask_flag(ui_flag), .nmi_ack(nmi_ack), .nmi_request(nmi_request), .req_valid(req_valid),
    .req_source(req_source), .req_level(req_level), .ui_mask_active(ui_mask_active), .irq(irq));

  cpu_accept_model cpu_u (
    .aclk(aclk), .aresetn(aresetn), .nmi_request(nmi_request), .want_i(want_i), .want_ui(want_ui),
    .ack_dly(ack_dly), .cpu_i_flag(cpu_i_flag), .user_or_mask_flag(ui_flag), .nmi_ack(nmi_ack));

  // ***************************
  // tasks
  // ***************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // axi write: address and data together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    awaddr  <= a;
    wdata   <= {24'h000000, d};
    wstrb   <= wr_strb;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        bready <= 1'b0;
        chk(32'(bresp), 32'(er));
        break;
      end
    end
    @(posedge aclk);  // idle edge so bready is not raised again in this step
  endtask

  task automatic rdr(input logic [7:0] a, input logic [1:0] er, output logic [7:0] d);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        rready <= 1'b0;
        chk(32'(rresp), 32'(er));
        chk(32'(rdata[31:8]), 32'h00000000);
        d = rdata[7:0];
        break;
      end
    end
    @(posedge aclk);  // idle edge so rready is not raised again in this step
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rdr(a, OK, d);
    chk(32'(d), 32'(exp));
  endtask

  // request outputs after inputs settle through the synchronisers
  task automatic rq(input logic v, input logic [3:0] s, input logic l);
    repeat (5) @(posedge aclk);
    chk(32'(req_valid), 32'(v));
    if (v) begin
      chk(32'(req_source), 32'(s));
      chk(32'(req_level), 32'(l));
    end
  endtask

  task automatic nmi_seen(input logic exp);
    logic s;
    s = 1'b0;
    repeat (16) begin
      @(posedge aclk);
      if (nmi_request === 1'b1) s = 1'b1;
    end
    chk(32'(s), 32'(exp));
  endtask

  task automatic test_done();
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ***************************
  // clock, timeout, sequence
  // ***************************
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // cuts a hang short
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      test_done();
    end
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, hw_standby, want_i, want_ui} = '0;
    {awaddr, araddr, wdata, wstrb, src_vec, ack_dly} = '0;
    nmi_pin = 1'b1;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rchk(SC, 8'h09);
    rchk(PA, 8'h00);
    wr(PA, 8'hA5, OK);
    rchk(PA, 8'hA5);
    // status ignores writes; strobe low blocks a write
    wr(ST, 8'hFF, OK);
    rchk(ST, 8'h00);
    wr_strb = 4'h0;
    wr(PA, 8'h3C, OK);
    wr_strb = 4'hF;
    rchk(PA, 8'hA5);
    rdr(8'h10, irq_prio_pkg::RESP_SLVERR, rd);
    chk(32'(rd), 32'h00000000);
    wr(8'h10, 8'h55, irq_prio_pkg::RESP_SLVERR);
    // each source alone, its own bit high then low
    for (int i = 0; i < 12; i++) begin
      src_vec <= 12'(12'h001 << i);
      wr(PA, 8'(8'h01 << pbit[i]), OK);
      rq(1'b1, 4'(i), 1'b1);
      wr(PA, 8'h00, OK);
      rq(1'b1, 4'(i), 1'b0);
    end
    // high level beats lower index; same level lowest index
    src_vec <= 12'h801;
    wr(PA, 8'h01, OK);
    rq(1'b1, 4'hB, 1'b1);
    wr(PA, 8'h00, OK);
    rq(1'b1, 4'h0, 1'b0);
    // mask flag roles by user_flag_select
    wr(PA, 8'h01, OK);
    want_i <= 1'b1;
    rq(1'b0, 4'h0, 1'b0);
    wr(SC, 8'h01, OK);
    rq(1'b1, 4'hB, 1'b1);
    chk(32'(ui_mask_active), 32'h00000001);
    want_ui <= 1'b1;
    rq(1'b0, 4'h0, 1'b0);
    want_ui <= 1'b0;
    src_vec <= 12'h000;
    // nmi edges with the i flag set, status and irq
    wr(SC, 8'h09, OK);
    rdr(ST, OK, rd);
    wr(MK, 8'h01, OK);
    nmi_pin <= 1'b0;
    nmi_seen(1'b1);
    chk(32'(irq), 32'h00000001);
    rchk(ST, 8'h01);
    repeat (2) @(posedge aclk);
    chk(32'(irq), 32'h00000000);
    ack_dly <= 4'h6;
    wr(SC, 8'h0D, OK);
    nmi_pin <= 1'b1;
    nmi_seen(1'b1);
    nmi_pin <= 1'b0;
    nmi_seen(1'b0);
    wr(MK, 8'h00, OK);
    nmi_pin <= 1'b1;
    nmi_seen(1'b1);
    chk(32'(irq), 32'h00000000);
    rchk(ST, 8'h01);
    // hardware standby reloads both registers
    want_i <= 1'b0;
    wr(MK, 8'h02, OK);
    wr(SC, 8'h05, OK);
    wr(PA, 8'hFF, OK);
    hw_standby <= 1'b1;
    repeat (4) @(posedge aclk);
    hw_standby <= 1'b0;
    repeat (4) @(posedge aclk);
    chk(32'(irq), 32'h00000001);
    rchk(SC, 8'h09);
    rchk(PA, 8'h00);
    rchk(ST, 8'h02);
    repeat (2) @(posedge aclk);
    chk(32'(irq), 32'h00000000);
    test_done();
  end
endmodule
